//--- hdl/mso_regs.vh
// Constants and register map for the motion status outputs block
`ifndef MSO_REGS_VH
`define MSO_REGS_VH
`define MSO_ADDR_CTRL 12'h000
`define MSO_ADDR_GPO 12'h004
`define MSO_ADDR_CMD 12'h008
`define MSO_ADDR_ENDAREA 12'h00C
`define MSO_ADDR_STATUS 12'h010
`define MSO_ADDR_ALARM 12'h014
`define MSO_ADDR_POSCMD 12'h018
`define MSO_ADDR_POSFB 12'h01C
`define MSO_ADDR_POSERR 12'h020
`define MSO_CTRL_END_SEL 0
`define MSO_CTRL_RDY_GATE 1
`define MSO_CMD_ALM_RESET 0
`define MSO_CMD_PAUSE 1
`define MSO_CMD_PAUSE_CANCEL 2
`define MSO_CMD_START 3
`define MSO_CMD_ABORT 4
`define MSO_CMD_FREE_SET 5
`define MSO_CMD_FREE_CLR 6
`define MSO_CMD_CUR_ON 7
`define MSO_CMD_CUR_OFF 8
`define MSO_CMD_ABS_MOVE 9
`define MSO_CMD_INC_MOVE 10
`define MSO_CMD_GOTO_ORIGIN 11
`define MSO_CMD_SET_ZERO 12
`define MSO_BLINK_ON_NS 250000000
`define MSO_BLINK_GAP_NS 1000000000
`define MSO_CLK_NS 5
`define MSO_ZERO32 32'h00000000
`endif

//--- hdl/mso_sync.v
// Two flip-flop synchroniser for a bank of pin inputs
`timescale 1ns/1ps
module mso_sync #(
  parameter W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] stage1;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // mso_sync

//--- hdl/mso_blink.v
// Alarm indicator blinker: shows the alarm code as a burst of blinks
`timescale 1ns/1ps
`include "mso_regs.vh"
module mso_blink #(
  parameter ON_CYC = `MSO_BLINK_ON_NS / `MSO_CLK_NS,
  parameter GAP_CYC = `MSO_BLINK_GAP_NS / `MSO_CLK_NS
) (
  input wire pclk,
  input wire presetn,
  input wire [3:0] code,
  output reg led
);
  reg [31:0] timer;
  reg [4:0] phase;
  wire [4:0] last_phase;
  assign last_phase = {code, 1'b0};
  // Phase odd = lit, even = dark; after the last phase a long gap marks the burst end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer <= `MSO_ZERO32;
      phase <= 5'h00;
      led <= 1'b0;
    end else if (code == 4'h0) begin
      timer <= `MSO_ZERO32;
      phase <= 5'h00;
      led <= 1'b0;
    end else if (timer != `MSO_ZERO32) begin
      timer <= timer - 32'h00000001;
    end else if (phase >= last_phase) begin
      // Dark gap; a lit gap would read as one extra blink
      phase <= 5'h00;
      led <= 1'b0;
      timer <= GAP_CYC[31:0];
    end else begin
      phase <= phase + 5'h01;
      led <= ~phase[0];
      timer <= ON_CYC[31:0];
    end
  end
endmodule // mso_blink

//--- hdl/mso_top.v
// Motion status outputs with APB register access
`timescale 1ns/1ps
`include "mso_regs.vh"
module mso_top #(
  parameter BLINK_ON_CYC = `MSO_BLINK_ON_NS / `MSO_CLK_NS,
  parameter BLINK_GAP_CYC = `MSO_BLINK_GAP_NS / `MSO_CLK_NS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Motion and sequence engine (same clock)
  input wire pulse_active,
  input wire pulse_done,
  input wire seq_executing,
  input wire seq_motion_started,
  input wire seq_last_cmd,
  input wire home_seek_done,
  input wire [3:0] alarm_cause,
  input wire alarm_cause_present,
  input wire engine_motion_req,
  input wire [31:0] feedback_position,
  input wire [31:0] engine_position_step,
  input wire engine_position_valid,
  // Pins (asynchronous)
  input wire pause_in,
  input wire pause_cancel,
  input wire start_in,
  input wire abort_in,
  input wire free_conn_in,
  input wire free_remote_in,
  input wire driver_end_in,
  input wire driver_ready_in,
  input wire driver_limit_in,
  input wire driver_moving_in,
  input wire sensorless_home_active,
  // Status outputs, one means transistor on
  output reg [3:0] general_output_n,
  output reg alarm_out,
  output reg alarm_led,
  output reg motion_end_out,
  output reg seq_running_out,
  output reg moving_out,
  output reg ready_out,
  output reg limit_condition_out,
  output reg pause_state_out,
  output reg home_found_out,
  output reg brake_release_out,
  output reg brake_release_drv_out,
  output reg motion_accept,
  output reg motion_rejected,
  output reg home_drv_moving
);
  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  wire [10:0] pin_raw;
  wire [10:0] pin_s;
  assign pin_raw = {sensorless_home_active, driver_moving_in, driver_limit_in,
                    driver_ready_in, driver_end_in, free_remote_in, free_conn_in,
                    abort_in, start_in, pause_cancel, pause_in};
  mso_sync #(.W(11)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(pin_raw),
    .dout(pin_s)
  );
  reg [4:0] pin_prev;
  wire [4:0] pin_rise;
  assign pin_rise = pin_s[4:0] & ~pin_prev;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= 5'h00;
    end else begin
      pin_prev <= pin_s[4:0];
    end
  end

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  reg end_source_select;
  reg driver_ready_gate;
  reg [31:0] end_area_setting;
  reg [31:0] commanded_position;
  reg [3:0] gpo;
  reg [3:0] alarm_code;
  reg free_cmd;
  reg motor_current;
  reg home_valid;
  wire wr;
  wire rd_ok;
  wire [12:0] cmd;
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign rd_ok = (paddr == `MSO_ADDR_CTRL) | (paddr == `MSO_ADDR_GPO)
               | (paddr == `MSO_ADDR_CMD) | (paddr == `MSO_ADDR_ENDAREA)
               | (paddr == `MSO_ADDR_STATUS) | (paddr == `MSO_ADDR_ALARM)
               | (paddr == `MSO_ADDR_POSCMD) | (paddr == `MSO_ADDR_POSFB)
               | (paddr == `MSO_ADDR_POSERR);
  assign pslverr = psel & penable & ~rd_ok;
  assign cmd = (wr && paddr == `MSO_ADDR_CMD) ? pwdata[12:0] : 13'h0000;

  wire [31:0] position_error;
  assign position_error = commanded_position - feedback_position;
  wire [31:0] status_word;
  assign status_word = {19'h00000, home_valid, free_cmd, motor_current, brake_release_out,
                        home_found_out, pause_state_out, limit_condition_out, ready_out,
                        moving_out, seq_running_out, motion_end_out, alarm_out, 1'b0};

  always @* begin
    case (paddr)
      `MSO_ADDR_CTRL: prdata = {30'h00000000, driver_ready_gate, end_source_select};
      `MSO_ADDR_GPO: prdata = {28'h0000000, gpo};
      `MSO_ADDR_ENDAREA: prdata = end_area_setting;
      `MSO_ADDR_STATUS: prdata = status_word;
      `MSO_ADDR_ALARM: prdata = {28'h0000000, alarm_code};
      `MSO_ADDR_POSCMD: prdata = commanded_position;
      `MSO_ADDR_POSFB: prdata = feedback_position;
      `MSO_ADDR_POSERR: prdata = position_error;
      default: prdata = `MSO_ZERO32;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_source_select <= 1'b0;
      driver_ready_gate <= 1'b0;
      end_area_setting <= `MSO_ZERO32;
      gpo <= 4'h0;
    end else if (wr) begin
      if (paddr == `MSO_ADDR_CTRL) begin
        end_source_select <= pwdata[`MSO_CTRL_END_SEL];
        driver_ready_gate <= pwdata[`MSO_CTRL_RDY_GATE];
      end
      if (paddr == `MSO_ADDR_GPO) begin
        gpo <= (gpo & ~pwdata[7:4]) | (pwdata[3:0] & pwdata[7:4]);
      end
      if (paddr == `MSO_ADDR_ENDAREA) begin
        end_area_setting <= pwdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // Alarm, current and brake
  // ------------------------------------------------------------------
  wire next_alarm;
  assign next_alarm = alarm_cause_present | (alarm_out & ~cmd[`MSO_CMD_ALM_RESET]);
  wire motion_cmd;
  assign motion_cmd = cmd[`MSO_CMD_ABS_MOVE] | cmd[`MSO_CMD_INC_MOVE]
                    | cmd[`MSO_CMD_GOTO_ORIGIN] | engine_motion_req;
  wire ready_now;
  assign ready_now = ~moving_out & ~seq_running_out & ~alarm_out
                   & (~driver_ready_gate | pin_s[7]);
  wire free_state;
  // Any one free source releases the brake, whatever the others say
  assign free_state = pin_s[4] | pin_s[5] | free_cmd;
  wire blink_led;
  mso_blink #(
    .ON_CYC(BLINK_ON_CYC),
    .GAP_CYC(BLINK_GAP_CYC)
  ) u_blink (
    .pclk(pclk),
    .presetn(presetn),
    .code(alarm_code),
    .led(blink_led)
  );
  wire at_origin;
  assign at_origin = (commanded_position == `MSO_ZERO32) & pulse_done & ~pulse_active;
  reg origin_target;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_out <= 1'b0;
      alarm_code <= 4'h0;
      motor_current <= 1'b0;
      free_cmd <= 1'b0;
    end else begin
      alarm_out <= next_alarm;
      if (alarm_cause_present) begin
        alarm_code <= alarm_cause;
      end else if (cmd[`MSO_CMD_ALM_RESET]) begin
        alarm_code <= 4'h0;
      end
      if (alarm_cause_present | cmd[`MSO_CMD_CUR_OFF]) begin
        motor_current <= 1'b0;
      end else if (cmd[`MSO_CMD_CUR_ON]) begin
        motor_current <= 1'b1;
      end
      if (cmd[`MSO_CMD_FREE_SET]) begin
        free_cmd <= 1'b1;
      end else if (cmd[`MSO_CMD_FREE_CLR]) begin
        free_cmd <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Status outputs
  // ------------------------------------------------------------------
  wire internal_end;
  assign internal_end = pulse_done & ~pulse_active
                      & ((end_area_setting == `MSO_ZERO32)
                      | ($signed(position_error) <= $signed(end_area_setting)
                        && $signed(position_error) >= -$signed(end_area_setting)));
  wire pause_clear;
  assign pause_clear = pin_rise[1] | pin_rise[2] | pin_rise[3] | cmd[`MSO_CMD_PAUSE_CANCEL]
                     | cmd[`MSO_CMD_START] | cmd[`MSO_CMD_ABORT];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_output_n <= 4'h0;
      alarm_led <= 1'b0;
      motion_end_out <= 1'b0;
      seq_running_out <= 1'b0;
      moving_out <= 1'b0;
      ready_out <= 1'b0;
      limit_condition_out <= 1'b0;
      pause_state_out <= 1'b0;
      home_found_out <= 1'b0;
      home_valid <= 1'b0;
      brake_release_out <= 1'b0;
      brake_release_drv_out <= 1'b0;
      motion_accept <= 1'b0;
      motion_rejected <= 1'b0;
      home_drv_moving <= 1'b0;
      commanded_position <= `MSO_ZERO32;
      origin_target <= 1'b0;
    end else begin
      general_output_n <= gpo;
      alarm_led <= blink_led;
      motion_end_out <= end_source_select ? pin_s[6] : internal_end;
      // Last motion command of a sequence ends running at its start, not its end
      seq_running_out <= seq_executing & ~(seq_last_cmd & seq_motion_started);
      moving_out <= pulse_active;
      ready_out <= ready_now;
      limit_condition_out <= pin_s[8];
      home_drv_moving <= pin_s[10] & pin_s[9];
      motion_accept <= motion_cmd & ~moving_out & ready_now;
      motion_rejected <= motion_cmd & (moving_out | ~ready_now);
      if (pin_rise[0] | cmd[`MSO_CMD_PAUSE]) begin
        pause_state_out <= 1'b1;
      end else if (pause_clear | ~moving_out) begin
        pause_state_out <= pause_state_out & ~pause_clear;
      end
      if (home_seek_done) begin
        commanded_position <= `MSO_ZERO32;
      end else if (cmd[`MSO_CMD_SET_ZERO]) begin
        commanded_position <= `MSO_ZERO32;
      end else if (engine_position_valid) begin
        commanded_position <= commanded_position + engine_position_step;
      end
      if (home_seek_done) begin
        home_valid <= 1'b1;
        home_found_out <= 1'b1;
      end else if (pulse_active) begin
        home_found_out <= 1'b0;
      end else if (home_valid & at_origin & origin_target) begin
        home_found_out <= 1'b1;
      end
      if (cmd[`MSO_CMD_GOTO_ORIGIN] | (cmd[`MSO_CMD_ABS_MOVE] & (pwdata[31:16] == 16'h0000))) begin
        origin_target <= 1'b1;
      end else if (motion_cmd) begin
        origin_target <= 1'b0;
      end
      brake_release_out <= motor_current | free_state;
      brake_release_drv_out <= motor_current | free_state;
    end
  end
endmodule // mso_top

//--- bench/mso_drv_model.sv
// Motor driver model for the end, ready, limit and moving lines
`timescale 1ns/1ps
module mso_drv_model (
  input wire pclk,
  input wire presetn,
  input wire [2:0] req,
  input wire [3:0] lag,
  output reg driver_end_in,
  output reg driver_ready_in,
  output reg driver_limit_in,
  output reg driver_moving_in
);
  reg [3:0] cnt;
  // A nonzero lag mimics a slow driver that answers late
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      driver_end_in <= 1'b0;
      driver_ready_in <= 1'b0;
      driver_limit_in <= 1'b0;
      driver_moving_in <= 1'b0;
    end else if (cnt < lag) begin
      cnt <= cnt + 4'h1;
    end else begin
      cnt <= 4'h0;
      driver_end_in <= req[0];
      driver_ready_in <= req[1];
      driver_limit_in <= req[2];
      driver_moving_in <= ~req[0];
    end
  end
endmodule // mso_drv_model

//--- bench/mso_props.sv
// Checker for the motion status outputs block
`timescale 1ns/1ps
module mso_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire pulse_active,
  input wire alarm_cause_present,
  input wire engine_motion_req,
  input wire driver_limit_in,
  input wire alarm_out,
  input wire moving_out,
  input wire ready_out,
  input wire limit_condition_out,
  input wire home_found_out,
  input wire brake_release_out,
  input wire brake_release_drv_out,
  input wire motion_accept
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------
  // Alarm steps, output and bus checks
  // ----------------
  sequence s_cause;
    alarm_cause_present;
  endsequence
  sequence s_raised;
    ##1 alarm_out;
  endsequence
  a_alarm_raise: assert property (s_cause |-> s_raised)
    else $error("alarm output not raised");
  a_alarm_hold: assert property ($fell(alarm_out) |-> !$past(alarm_cause_present))
    else $error("alarm output cleared while cause present");
  a_moving_follow: assert property (moving_out == $past(pulse_active))
    else $error("moving output does not follow pulse generation");
  a_motion_reject: assert property (engine_motion_req && moving_out |->
    !motion_accept ##1 !motion_accept) else $error("motion accepted while moving");
  a_ready_block: assert property (pulse_active [*2] |=> !ready_out)
    else $error("ready output high while moving");
  a_limit_mirror: assert property (limit_condition_out == $past(driver_limit_in, 3))
    else $error("limit output does not follow driver input");
  a_brake_same: assert property (brake_release_out == brake_release_drv_out)
    else $error("brake release outputs differ");
  a_home_drop: assert property (pulse_active [*2] |=> !home_found_out)
    else $error("home found high while moving");
  a_bus_ready: assert property (psel && penable |-> pready)
    else $error("bus ready low in access phase");
  a_bus_unmapped: assert property (psel && penable && paddr > 12'h020 |-> pslverr)
    else $error("no error on unmapped address");
endmodule // mso_props
bind mso_top mso_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .pulse_active(pulse_active), .alarm_cause_present(alarm_cause_present),
  .engine_motion_req(engine_motion_req), .driver_limit_in(driver_limit_in),
  .alarm_out(alarm_out), .moving_out(moving_out), .ready_out(ready_out),
  .limit_condition_out(limit_condition_out), .home_found_out(home_found_out),
  .brake_release_out(brake_release_out), .brake_release_drv_out(brake_release_drv_out),
  .motion_accept(motion_accept));

//--- bench/mso_top_tb.sv
// Testbench for the motion status outputs block
`timescale 1ns/1ps
`include "mso_regs.vh"
module mso_top_tb;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg pact = 1'b0, pdone = 1'b1, sexe = 1'b0, hdone = 1'b0, acp = 1'b0, mreq = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, fbpos = 32'h0, rd;
  reg [3:0] acause = 4'h0, lag = 4'h2;
  reg [6:0] pin = 7'h00;
  reg [2:0] req = 3'h0;
  reg err_seen;
  reg smst = 1'b0, slast = 1'b0, pval = 1'b0, aprev;
  reg [31:0] pstep = 32'h0;
  integer nbl;
  integer num_errors = 0, total_checks = 0, cyc = 0, i;
  wire [31:0] prdata;
  wire [3:0] gpo;
  wire pready, pslverr, d_end, d_rdy, d_lim, d_mov, alarm_query_cmd, wait_motion_finish_cmd, run, mov, rdy, lim, pst;
  wire home, brk, brkd, aled, macc, mrej, hmov;
  // Short blink counts keep the indicator busy within the run
  mso_top #(.BLINK_ON_CYC(4), .BLINK_GAP_CYC(16)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_active(pact),
    .pulse_done(pdone), .seq_executing(sexe), .seq_motion_started(smst),
    .seq_last_cmd(slast), .home_seek_done(hdone), .alarm_cause(acause),
    .alarm_cause_present(acp), .engine_motion_req(mreq), .feedback_position(fbpos),
    .engine_position_step(pstep), .engine_position_valid(pval), .pause_in(pin[0]),
    .pause_cancel(pin[1]), .start_in(pin[2]), .abort_in(pin[3]), .free_conn_in(pin[4]),
    .free_remote_in(pin[5]), .driver_end_in(d_end), .driver_ready_in(d_rdy),
    .driver_limit_in(d_lim), .driver_moving_in(d_mov), .sensorless_home_active(pin[6]),
    .general_output_n(gpo), .alarm_out(alarm_query_cmd), .alarm_led(aled), .motion_end_out(wait_motion_finish_cmd),
    .seq_running_out(run), .moving_out(mov), .ready_out(rdy), .limit_condition_out(lim),
    .pause_state_out(pst), .home_found_out(home), .brake_release_out(brk),
    .brake_release_drv_out(brkd), .motion_accept(macc), .motion_rejected(mrej),
    .home_drv_moving(hmov));
  mso_drv_model i_drv (.pclk(pclk), .presetn(presetn), .req(req), .lag(lag),
    .driver_end_in(d_end), .driver_ready_in(d_rdy), .driver_limit_in(d_lim),
    .driver_moving_in(d_mov));
  always #2.5 pclk = ~pclk;
  // ----------------
  // Shared tasks
  // ----------------
  task wt(input integer n);
    // Checks just after an edge see what settled before it
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cmd(input integer b);
    apb(1'b1, `MSO_ADDR_CMD, 32'h1 << b);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task t_regs_gpo;
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err_seen});
    apb(1'b1, `MSO_ADDR_GPO, 32'hFA);
    wt(2);
    chk("gpo all", 32'hA, {28'h0, gpo});
    apb(1'b1, `MSO_ADDR_GPO, 32'h11);
    apb(1'b0, `MSO_ADDR_GPO, 32'h0);
    chk("gpo one", 32'hB, rd);
  endtask
  task t_end;
    wt(2);
    chkb("end pulse", 1'b1, wait_motion_finish_cmd);
    pdone <= 1'b0;
    wt(3);
    chkb("end busy", 1'b0, wait_motion_finish_cmd);
    pdone <= 1'b1;
    fbpos <= 32'h5;
    apb(1'b1, `MSO_ADDR_ENDAREA, 32'h4);
    wt(3);
    chkb("end outside", 1'b0, wait_motion_finish_cmd);
    fbpos <= 32'h4;
    wt(3);
    chkb("end edge", 1'b1, wait_motion_finish_cmd);
    apb(1'b0, `MSO_ADDR_POSERR, 32'h0);
    chk("error", 32'hFFFFFFFC, rd);
    req <= 3'h2;
    pin[6] <= 1'b1;
    apb(1'b1, `MSO_ADDR_CTRL, 32'h1);
    wt(8);
    chkb("drv end low", 1'b0, wait_motion_finish_cmd);
    chkb("drv moving", 1'b0, mov);
    chkb("home drv moving", 1'b1, hmov);
    req <= 3'h3;
    wt(8);
    chkb("drv end high", 1'b1, wait_motion_finish_cmd);
    chkb("home drv idle", 1'b0, hmov);
    pin[6] <= 1'b0;
  endtask
  task t_ready;
    req <= 3'h1;
    apb(1'b1, `MSO_ADDR_CTRL, 32'h2);
    wt(8);
    chkb("gate off", 1'b0, rdy);
    req <= 3'h7;
    wt(8);
    chkb("gate on", 1'b1, rdy);
    chkb("limit on", 1'b1, lim);
    pact <= 1'b1;
    wt(2);
    mreq <= 1'b1;
    wt(1);
    mreq <= 1'b0;
    wt(1);
    chkb("rejected", 1'b1, mrej);
    chkb("not accepted", 1'b0, macc);
    wt(1);
    chkb("moving", 1'b1, mov);
    chkb("ready moving", 1'b0, rdy);
    pact <= 1'b0;
    sexe <= 1'b1;
    wt(4);
    chkb("running", 1'b1, run);
    chkb("ready running", 1'b0, rdy);
    slast <= 1'b1;
    smst <= 1'b1;
    wt(3);
    chkb("run last move", 1'b0, run);
    sexe <= 1'b0;
    slast <= 1'b0;
    smst <= 1'b0;
    wt(4);
    chkb("run done", 1'b0, run);
    chkb("ready again", 1'b1, rdy);
    mreq <= 1'b1;
    wt(1);
    mreq <= 1'b0;
    wt(1);
    chkb("accepted", 1'b1, macc);
  endtask
  task t_alarm;
    acause <= 4'h3;
    acp <= 1'b1;
    wt(3);
    chkb("alarm set", 1'b1, alarm_query_cmd);
    // With the short counts a burst of three plus its gap spans 47 cycles
    nbl = 0;
    aprev = aled;
    for (i = 0; i < 47; i = i + 1) begin
      @(posedge pclk);
      if (aled && !aprev) nbl = nbl + 1;
      aprev = aled;
    end
    chk("blinks", 32'h3, nbl);
    apb(1'b0, `MSO_ADDR_ALARM, 32'h0);
    chk("alarm code", 32'h3, rd);
    cmd(`MSO_CMD_ALM_RESET);
    acp <= 1'b0;
    wt(3);
    chkb("alarm held", 1'b1, alarm_query_cmd);
    cmd(`MSO_CMD_ALM_RESET);
    wt(3);
    chkb("alarm clear", 1'b0, alarm_query_cmd);
  endtask
  task t_pause;
    for (i = 0; i < 6; i = i + 1) begin
      cmd(`MSO_CMD_PAUSE);
      wt(2);
      chkb("paused", 1'b1, pst);
      if (i < 3) cmd(`MSO_CMD_PAUSE_CANCEL + i);
      else pin[i - 2] <= 1'b1;
      wt(5);
      pin[3:1] <= 3'h0;
      chkb("unpaused", 1'b0, pst);
    end
  endtask
  task t_brake;
    cmd(`MSO_CMD_CUR_ON);
    wt(2);
    chkb("brake current", 1'b1, brk);
    acp <= 1'b1;
    wt(4);
    chkb("brake alarm", 1'b0, brk);
    acp <= 1'b0;
    cmd(`MSO_CMD_ALM_RESET);
    cmd(`MSO_CMD_CUR_OFF);
    for (i = 0; i < 3; i = i + 1) begin
      if (i == 0) cmd(`MSO_CMD_FREE_SET);
      else pin[3 + i] <= 1'b1;
      wt(5);
      chkb("brake free", 1'b1, brk);
      cmd(`MSO_CMD_FREE_CLR);
      pin[5:4] <= 2'h0;
      wt(5);
      chkb("brake lock", 1'b0, brkd);
    end
  endtask
  task t_home;
    pstep <= 32'h5;
    pval <= 1'b1;
    wt(1);
    pval <= 1'b0;
    apb(1'b0, `MSO_ADDR_POSCMD, 32'h0);
    chk("pos step", 32'h5, rd);
    hdone <= 1'b1;
    wt(1);
    hdone <= 1'b0;
    wt(2);
    chkb("home found", 1'b1, home);
    apb(1'b0, `MSO_ADDR_POSCMD, 32'h0);
    chk("home pos", 32'h0, rd);
    pact <= 1'b1;
    wt(3);
    chkb("home moving", 1'b0, home);
    pact <= 1'b0;
    wt(3);
    chkb("home not yet", 1'b0, home);
    cmd(`MSO_CMD_GOTO_ORIGIN);
    wt(3);
    chkb("home again", 1'b1, home);
  endtask
  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs_gpo;
    t_end;
    t_ready;
    t_alarm;
    t_pause;
    t_brake;
    t_home;
    print_verdict;
  end
endmodule // mso_top_tb
